// file: sbrg_checker_properties.sv
// Purpose: port assertions for sbrg_top
// Assumes: one wait cycle per bus access
// Notes:   bound by name, sees ports only
`timescale 1ns/1ps
`default_nettype none
module sbrg_checker
(
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic        por_n,
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  avs_response,
    input wire logic        rate_tick,
    input wire logic        bit_rate_en,
    input wire logic [7:0]  serial_rx_ctrl_status,
    input wire logic [7:0]  serial_tx_ctrl_status
);
    // ---
    // properties
    // ---
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence acc_start; $rose(avs_read || avs_write); endsequence
    sequence acc_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
    sequence rd_done; avs_read && !avs_waitrequest; endsequence
    sequence slave_on; serial_tx_ctrl_status[4] && !serial_tx_ctrl_status[7]; endsequence
    bus_wait_a: assert property (acc_start |-> acc_wait)
        else $error("access not answered after one wait");
    unmapped_rd_a: assert property (rd_done and avs_address == 10'h000 |-> avs_response == 2'h2)
        else $error("unmapped read not flagged");
    read_upper_a: assert property (rd_done |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    // slave takes its clock from outside, so one settle cycle then silence
    slave_quiet_a: assert property (slave_on [*2] |-> !rate_tick && !bit_rate_en)
        else $error("generator runs in slave mode");
    rate_gap_a: assert property (bit_rate_en |=> !bit_rate_en [*3])
        else $error("bit rate pulses too close");
    rx_unused_a: assert property (serial_rx_ctrl_status[3:1] == 3'h0)
        else $error("rx status unused bits set");
    tx_unused_a: assert property (serial_tx_ctrl_status[3:2] == 2'h0)
        else $error("tx status unused bits set");
    por_clear_a: assert property ($rose(por_n) |-> serial_rx_ctrl_status[7:1] == 7'h00)
        else $error("rx status not cleared at power-on");
endmodule
bind sbrg_top sbrg_checker u_chk
(
    .core_clk              (core_clk),
    .arst_n                (arst_n),
    .por_n                 (por_n),
    .avs_address           (avs_address),
    .avs_read              (avs_read),
    .avs_write             (avs_write),
    .avs_readdata          (avs_readdata),
    .avs_waitrequest       (avs_waitrequest),
    .avs_response          (avs_response),
    .rate_tick             (rate_tick),
    .bit_rate_en           (bit_rate_en),
    .serial_rx_ctrl_status (serial_rx_ctrl_status),
    .serial_tx_ctrl_status (serial_tx_ctrl_status)
);
`default_nettype wire

// file: sbrg_pkg.sv
// Purpose: constants for the serial baud rate generator
// Assumes: 8-bit registers, one word per register on the bus
// Notes:   offsets are register indices; byte address is four times the index
package sbrg_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] RX_CTRL_IDX  = 8'h13;
    localparam logic [7:0] TX_CTRL_IDX  = 8'h15;
    localparam logic [7:0] DIVISOR_IDX  = 8'h17;
    localparam logic [7:0] RX_CTRL_MASK = 8'hf7;
    localparam logic [7:0] TX_CTRL_MASK = 8'hf3;
    localparam logic [7:0] RX_WR_MASK   = 8'hf1;
    localparam logic [7:0] TX_WR_MASK   = 8'hf1;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int MASTER_BIT  = 7;
    localparam int SYNC_BIT    = 4;
    localparam int TX_IDLE_BIT = 1;
    localparam int NINTH_BIT   = 0;
    // ----------------------------------------------------------------
    // reset values and post-divider top counts
    // ----------------------------------------------------------------
    localparam logic [7:0] RX_CTRL_RST = 8'h00;
    localparam logic [7:0] TX_CTRL_RST = 8'h02;
    localparam logic [7:0] DIVISOR_RST = 8'h00;
    localparam logic [5:0] ASYNC_POST  = 6'h3f;
    localparam logic [5:0] SYNC_POST   = 6'h03;
    typedef enum logic [1:0] {SBRG_IDLE = 2'b00, SBRG_ACK = 2'b01} sbrg_bus_e;
endpackage

// file: sbrg_tick_if.sv
// Purpose: carries divisor and control between register file and timer
// Assumes: single clock
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface sbrg_tick_if;
    logic [7:0] divisor;
    logic       reload;
    logic       sync_mode;
    logic       run;
    logic       tick;
    logic       rate;
    modport ctrl (output divisor, output reload, output sync_mode, output run,
                  input tick, input rate);
    modport gen  (input divisor, input reload, input sync_mode, input run,
                  output tick, output rate);
endinterface
`default_nettype wire

// file: sbrg_timer.sv
// Purpose: 8-bit reload timer and rate post-divider
// Assumes: run low holds the counter at the divisor and the post-divider cleared
// Notes:   tick is the raw timer expiry, rate the bit-clock enable
`timescale 1ns/1ps
`default_nettype none
module sbrg_timer
(
    input  wire logic core_clk,
    input  wire logic arst_n,
    sbrg_tick_if.gen  tif
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [5:0] post_r;
    logic [5:0] post_nxt;
    logic       expire;
    logic [5:0] post_top;

    // ----------------------------------------------------------------
    // timer and post-divider
    // ----------------------------------------------------------------
    always_comb
    begin
        expire   = tif.run && (cnt_r == 8'h00);
        post_top = tif.sync_mode ? sbrg_pkg::SYNC_POST : sbrg_pkg::ASYNC_POST;
        cnt_nxt  = cnt_r;
        post_nxt = post_r;
        if (tif.reload || !tif.run)
        begin
            cnt_nxt  = tif.divisor;
            post_nxt = 6'h00;
        end
        else if (expire)
        begin
            cnt_nxt  = tif.divisor;
            post_nxt = (post_r == post_top) ? 6'h00 : post_r + 6'h01;
        end
        else
        begin
            cnt_nxt = cnt_r - 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r  <= 8'h00;
            post_r <= 6'h00;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            post_r <= post_nxt;
        end
    end

    assign tif.tick = expire && !tif.reload;
    assign tif.rate = tif.tick && (post_r == post_top);
endmodule
`default_nettype wire

// file: sbrg_top.sv
// Purpose: baud rate generator with its serial control registers
// Assumes: Avalon-MM slave, word per register, one wait cycle per access
// Notes:   por_n clears the register file; arst_n is the pin or watchdog reset
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module sbrg_top
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        por_n,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [1:0]       avs_response,
    input  wire logic        tx_idle,
    input  wire logic        rx_ninth_bit_in,
    input  wire logic        rx_ninth_bit_load,
    output logic             rate_tick,
    output logic             bit_rate_en,
    output logic [7:0]       serial_rx_ctrl_status,
    output logic [7:0]       serial_tx_ctrl_status
);
    sbrg_tick_if tif();

    // register storage and next values
    logic [7:0]  rx_r;
    logic [7:0]  rx_nxt;
    logic [7:0]  tx_r;
    logic [7:0]  tx_nxt;
    logic [7:0]  div_r;
    logic [7:0]  div_nxt;
    logic        tx9_r;
    logic        tx9_nxt;
    logic        rx9_r;
    logic        rx9_nxt;

    // bus answer
    logic        ack_r;
    logic        ack_nxt;
    logic [31:0] rd_r;
    logic [31:0] rd_nxt;
    logic [1:0]  resp_r;
    logic [1:0]  resp_nxt;

    // decode and views
    logic        hit_any;
    logic        wr_commit;
    logic        wr_lane;
    logic        div_hit;
    logic [7:0]  rx_view;
    logic [7:0]  tx_view;

    function automatic logic is_reg(input logic [9:0] a, input logic [7:0] i);
        is_reg = (a[1:0] == 2'b00) && (a[9:2] == i);
    endfunction

    // ----------------------------------------------------------------
    // read views
    // ----------------------------------------------------------------
    always_comb
    begin
        rx_view = (rx_r & sbrg_pkg::RX_CTRL_MASK & ~8'h01) | {7'h00, rx9_r};
        tx_view = (tx_r & sbrg_pkg::TX_CTRL_MASK & 8'hfc) | {6'h00, tx_idle, tx9_r};
        hit_any = is_reg(avs_address, sbrg_pkg::RX_CTRL_IDX)
                || is_reg(avs_address, sbrg_pkg::TX_CTRL_IDX)
                || is_reg(avs_address, sbrg_pkg::DIVISOR_IDX);
    end

    // ----------------------------------------------------------------
    // bus slave: one wait cycle, then acknowledge
    // ----------------------------------------------------------------
    // read data is caught at the first edge so that it stands while
    // waitrequest is low; the answer never depends on the wait state
    always_comb
    begin
        ack_nxt  = (avs_read || avs_write) && !ack_r;
        rd_nxt   = rd_r;
        resp_nxt = resp_r;
        if (ack_nxt)
        begin
            resp_nxt = hit_any ? 2'b00 : 2'b10;
            rd_nxt   = 32'h0000_0000;
            if (avs_read)
            begin
                if (is_reg(avs_address, sbrg_pkg::RX_CTRL_IDX))
                    rd_nxt = {24'h000000, rx_view};
                else if (is_reg(avs_address, sbrg_pkg::TX_CTRL_IDX))
                    rd_nxt = {24'h000000, tx_view};
                else if (is_reg(avs_address, sbrg_pkg::DIVISOR_IDX))
                    rd_nxt = {24'h000000, div_r};
            end
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    // a write lands only at the edge where waitrequest is seen low, so a
    // master that drops its request early leaves the registers alone
    always_comb
    begin
        wr_commit = ack_r && avs_write;
        wr_lane   = wr_commit && avs_byteenable[0];
        div_hit   = wr_lane && is_reg(avs_address, sbrg_pkg::DIVISOR_IDX);
        rx_nxt    = rx_r;
        tx_nxt    = tx_r;
        div_nxt   = div_r;
        tx9_nxt   = tx9_r;
        rx9_nxt   = rx_ninth_bit_load ? rx_ninth_bit_in : rx9_r;
        if (wr_lane)
        begin
            if (is_reg(avs_address, sbrg_pkg::RX_CTRL_IDX))
                rx_nxt = avs_writedata[7:0] & sbrg_pkg::RX_WR_MASK;
            else if (is_reg(avs_address, sbrg_pkg::TX_CTRL_IDX))
            begin
                tx_nxt  = avs_writedata[7:0] & sbrg_pkg::TX_WR_MASK;
                tx9_nxt = avs_writedata[sbrg_pkg::NINTH_BIT];
            end
            else if (div_hit)
                div_nxt = avs_writedata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    // either reset clears control and error bits; pin reset leaves the ninth bits as they are
    always_ff @(posedge core_clk or negedge por_n)
    begin
        if (!por_n)
        begin
            rx_r <= sbrg_pkg::RX_CTRL_RST;
            tx_r <= sbrg_pkg::TX_CTRL_RST;
        end
        else if (!arst_n)
        begin
            rx_r <= sbrg_pkg::RX_CTRL_RST;
            tx_r <= sbrg_pkg::TX_CTRL_RST;
        end
        else
        begin
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
        end
    end

    // divisor and ninth bits survive pin or watchdog reset
    always_ff @(posedge core_clk or negedge por_n)
    begin
        if (!por_n)
        begin
            div_r <= sbrg_pkg::DIVISOR_RST;
            tx9_r <= 1'b0;
            rx9_r <= 1'b0;
        end
        else if (arst_n)
        begin
            div_r <= div_nxt;
            tx9_r <= tx9_nxt;
            rx9_r <= rx9_nxt;
        end
    end

    // bus answer registers, cleared by arst_n only
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_r  <= 1'b0;
            rd_r   <= 32'h0000_0000;
            resp_r <= 2'b00;
        end
        else
        begin
            ack_r  <= ack_nxt;
            rd_r   <= rd_nxt;
            resp_r <= resp_nxt;
        end
    end

    // ----------------------------------------------------------------
    // generator hookup
    // ----------------------------------------------------------------
    // next divisor, so a reload at the write edge takes the value just written
    assign tif.divisor   = div_nxt;
    assign tif.reload    = div_hit;
    assign tif.sync_mode = tx_r[sbrg_pkg::SYNC_BIT];
    // a synchronous slave is clocked from outside, so the timer sleeps
    assign tif.run       = !tx_r[sbrg_pkg::SYNC_BIT] || tx_r[sbrg_pkg::MASTER_BIT];

    // ----------------------------------------------------------------
    // rate timer
    // ----------------------------------------------------------------
    sbrg_timer u_timer
    (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .tif      (tif)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // status views are live, so a transmitter change shows at once
    assign rate_tick             = tif.tick;
    assign bit_rate_en           = tif.rate;
    assign avs_readdata          = rd_r;
    assign avs_response          = resp_r;
    assign avs_waitrequest       = (avs_read || avs_write) && !ack_r;
    assign serial_rx_ctrl_status = rx_view;
    assign serial_tx_ctrl_status = tx_view;
endmodule
`default_nettype wire

// file: tb_serial_baud_rate_generator.sv
// Purpose: directed register and rate tests for sbrg_top
// Assumes: design answers each access after one wait cycle
// Notes:   prescaled rate timed with a small divisor to keep the run short
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tb_serial_baud_rate_generator;
    localparam logic [9:0] RXA = 10'h04c;
    localparam logic [9:0] TXA = 10'h054;
    localparam logic [9:0] DVA = 10'h05c;
    logic        core_clk, arst_n, por_n, avs_read, avs_write, avs_waitrequest;
    logic        tx_idle, rx_ninth_bit_in, rx_ninth_bit_load, rate_tick, bit_rate_en;
    logic [9:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  avs_byteenable;
    logic [1:0]  avs_response, rsp;
    logic [7:0]  serial_rx_ctrl_status, serial_tx_ctrl_status;
    logic [7:0]  dv [3] = '{8'h00, 8'h03, 8'hff};
    int          n_fail, compares, c;
    sbrg_top dut_u
    (
        .core_clk              (core_clk),
        .arst_n                (arst_n),
        .por_n                 (por_n),
        .avs_address           (avs_address),
        .avs_read              (avs_read),
        .avs_write             (avs_write),
        .avs_writedata         (avs_writedata),
        .avs_byteenable        (avs_byteenable),
        .avs_readdata          (avs_readdata),
        .avs_waitrequest       (avs_waitrequest),
        .avs_response          (avs_response),
        .tx_idle               (tx_idle),
        .rx_ninth_bit_in       (rx_ninth_bit_in),
        .rx_ninth_bit_load     (rx_ninth_bit_load),
        .rate_tick             (rate_tick),
        .bit_rate_en           (bit_rate_en),
        .serial_rx_ctrl_status (serial_rx_ctrl_status),
        .serial_tx_ctrl_status (serial_tx_ctrl_status)
    );
    // ---
    // bus and timing tasks
    // ---
    task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= {24'h0, d};
        do
            @(posedge core_clk);
        while (avs_waitrequest !== 1'b0);
        q   = avs_readdata;
        rsp = avs_response;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        // idle edge so the next call never drives the same step twice
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        `CHK({rsp, q}, {2'h0, 24'h0, e})
    endtask
    task automatic till(input logic en, output int n);
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while ((en ? bit_rate_en : rate_tick) !== 1'b1);
    endtask
    task automatic results;
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever
            #2 core_clk = ~core_clk;
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        results;
    end
    initial
    begin
        {arst_n, por_n, avs_read, avs_write, rx_ninth_bit_in, rx_ninth_bit_load} <= 6'h00;
        {avs_address, avs_writedata, avs_byteenable, tx_idle} <= {42'h0, 4'h1, 1'b1};
        {n_fail, compares} = 64'h0;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        por_n  <= 1'b1;
        @(posedge core_clk);
        rd(RXA, 8'h00);
        rd(TXA, 8'h02);
        tx_idle <= 1'b0;
        rd(TXA, 8'h00);
        tx_idle <= 1'b1;
        acc(1'b1, TXA, 8'hff);
        rd(TXA, 8'hf3);
        `CHK(serial_tx_ctrl_status, 8'hf3)
        acc(1'b1, RXA, 8'hfe);
        rd(RXA, 8'hf0);
        rx_ninth_bit_in   <= 1'b1;
        rx_ninth_bit_load <= 1'b1;
        @(posedge core_clk);
        rx_ninth_bit_load <= 1'b0;
        rd(RXA, 8'hf1);
        `CHK(serial_rx_ctrl_status, 8'hf1)
        acc(1'b1, TXA, 8'h01);
        foreach (dv[i])
        begin
            acc(1'b1, DVA, dv[i]);
            till(1'b0, c);
            till(1'b0, c);
            `CHK(c, int'(dv[i]) + 1)
        end
        acc(1'b1, DVA, 8'h03);
        till(1'b1, c);
        till(1'b1, c);
        `CHK(c, 256)
        acc(1'b1, TXA, 8'h91);
        till(1'b1, c);
        till(1'b1, c);
        `CHK(c, 16)
        acc(1'b1, TXA, 8'h11);
        c = 0;
        repeat (300)
        begin
            @(negedge core_clk);
            if (rate_tick !== 1'b0)
                c++;
        end
        `CHK(c, 0)
        acc(1'b1, TXA, 8'h01);
        acc(1'b1, DVA, 8'hff);
        repeat (20) @(posedge core_clk);
        acc(1'b1, DVA, 8'h02);
        till(1'b0, c);
        `CHK(c <= 4, 1'b1)
        acc(1'b1, 10'h000, 8'h55);
        acc(1'b0, 10'h000, 8'h00);
        `CHK({rsp, q}, {2'h2, 32'h0})
        rd(DVA, 8'h02);
        avs_byteenable <= 4'h0;
        acc(1'b1, DVA, 8'h77);
        avs_byteenable <= 4'h1;
        rd(DVA, 8'h02);
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        rd(DVA, 8'h02);
        rd(TXA, 8'h03);
        rd(RXA, 8'h01);
        {por_n, arst_n} <= 2'b00;
        repeat (2) @(posedge core_clk);
        {por_n, arst_n} <= 2'b11;
        @(posedge core_clk);
        rd(RXA, 8'h00);
        results;
    end
endmodule
`default_nettype wire
